//--- hdl/lcd_comp_pkg.sv
package lcd_comp_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_VPROG    = 4'h1;
  localparam logic [3:0] REG_SLOPE_AB = 4'h2;
  localparam logic [3:0] REG_SLOPE_CD = 4'h3;
  localparam logic [3:0] REG_TEMP     = 4'h4;
  localparam logic [3:0] REG_OFFSET   = 4'h5;
  localparam logic [3:0] REG_TARGET   = 4'h6;
  localparam logic [3:0] REG_STATUS   = 4'h7;

  // control register fields
  localparam int CTRL_MEAS_BIT   = 0;
  localparam int CTRL_COMP_BIT   = 1;
  localparam int CTRL_PUMP_BIT   = 2;
  localparam int CTRL_MULT_BIT   = 3;
  localparam int CTRL_FILT_BIT   = 4;
  localparam int CTRL_EXT_BIT    = 5;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // slope register fields: low selector in [2:0], high selector in [6:4]
  localparam int SLOPE_LO_POS = 0;
  localparam int SLOPE_HI_POS = 4;
  localparam logic [2:0] SLOPE_RESET = 3'h0;
  localparam logic [7:0] VPROG_RESET = 8'h00;

  // status register fields
  localparam int STAT_CONV_BIT = 0;
  localparam int STAT_PUMP_BIT = 1;
  localparam int STAT_DIFF_BIT = 2;

  // temperature code at 20 degC: (20 + 40) / 0.9375
  localparam logic [7:0] TEMP_RESET = 8'h40;
  // region edges in code units (-40, -10, 20, 50, 80 degC)
  localparam logic [7:0] EDGE_M40 = 8'h00;
  localparam logic [7:0] EDGE_M10 = 8'h20;
  localparam logic [7:0] EDGE_P20 = 8'h40;
  localparam logic [7:0] EDGE_P50 = 8'h60;
  localparam logic [7:0] EDGE_P80 = 8'h80;
  // temperature in sixteenths of a degree: code * 15 - 640
  localparam logic signed [19:0] T16_GAIN = 20'sd15;
  localparam logic signed [19:0] T16_BASE = 20'sd640;
  localparam logic signed [19:0] T16_M10  = -20'sd160;
  localparam logic signed [19:0] T16_P20  = 20'sd320;
  localparam logic signed [19:0] T16_P50  = 20'sd800;
  localparam logic signed [19:0] SPAN16   = 20'sd480;  // 30 degC
  localparam logic signed [19:0] STEP16   = 20'sd480;  // 30 mV step

  // drive voltage code: 3 V + code * 30 mV, limited at 9 V
  localparam int LCD_DRIVE_VOLTAGE_BASE_MV = 3000;
  localparam int LCD_DRIVE_VOLTAGE_STEP_MV = 30;
  localparam int LCD_DRIVE_VOLTAGE_MAX_MV  = 9000;
  localparam logic [7:0] LCD_DRIVE_VOLTAGE_MAX_CODE =
    8'((LCD_DRIVE_VOLTAGE_MAX_MV - LCD_DRIVE_VOLTAGE_BASE_MV) / LCD_DRIVE_VOLTAGE_STEP_MV);

  // measurement timing
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int MEAS_TIME_US    = 5000;
  localparam int MEAS_CYCLES_DEF = MEAS_TIME_US * 1000 / CLOCK_PERIOD_NS;
  localparam int MEAS_FRAMES     = 200;

  typedef enum logic [0:0] {
    MEAS_IDLE    = 1'b0,
    MEAS_CONVERT = 1'b1
  } meas_state_e;

  // slope factor in mV/degC for a 3-bit selector
  function automatic logic signed [7:0] slope_mv(input logic [2:0] sel);
    case (sel)
      3'h1:    slope_mv = -8'sd4;
      3'h2:    slope_mv = -8'sd8;
      3'h3:    slope_mv = -8'sd16;
      3'h4:    slope_mv = -8'sd40;
      3'h5:    slope_mv = 8'sd4;
      3'h6:    slope_mv = 8'sd8;
      3'h7:    slope_mv = 8'sd16;
      default: slope_mv = 8'sd0;
    endcase
  endfunction

endpackage

//--- hdl/lcd_voltage_comp.sv
// Overview of operation
// - external supply: no compensation, code ignored
// - pump follows its enable bit
// - multiplier bit selects pump setting, max 3x
// - target is programmed code plus offset
// - programmed voltage is code times 30mV plus 3V
// - offset code is two's complement, zero at 20C
// - target limited to 9.0 V
// - 8-bit temperature code readable by host
// - degrees equal 0.9375 times code minus 40
// - periodic 5 ms measurement while enabled
// - repeat interval counted in frames
// - optional filter removes LSB jitter
// - filter off by default, raw value used
// - compensation only while comp enable set
// - four regions, each with own slope
// - selector to slope factor mapping
// - offset applied in 30 mV steps
// - low temperature offset formulas
// - high temperature offset formulas, held above 80C
// - sum saturates instead of wrapping
// - measurement enabled after reset
// - pump off after reset
`timescale 1ns/1ns
`default_nettype none
module lcd_voltage_comp
  import lcd_comp_pkg::*;
#(
  parameter int MEAS_CYCLES = lcd_comp_pkg::MEAS_CYCLES_DEF
)
(
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic [lcd_comp_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [lcd_comp_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  output logic      [lcd_comp_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                              frame_tick,
  input  wire logic [7:0]                        sensor_code,
  output logic                                   sensor_active,
  output logic                                   temp_update,
  output logic                                   pump_on,
  output logic                                   pump_triple,
  output logic      [7:0]                        drive_target_code,
  output logic                                   drive_target_valid
);
  import lcd_comp_pkg::*;

  typedef struct packed {
    logic        measure_enable;
    logic        comp_enable;
    logic        pump_enable;
    logic        pump_mult;
    logic        filter_enable;
    logic        ext_supply;
    logic [7:0]  vprog;
    logic [2:0]  sel_a;
    logic [2:0]  sel_b;
    logic [2:0]  sel_c;
    logic [2:0]  sel_d;
    meas_state_e meas;
    logic [7:0]  frame_cnt;
    logic [15:0] conv_cnt;
    logic [7:0]  raw;
    logic [7:0]  temp;
    logic [1:0]  trend;
    logic        fresh;
    logic [7:0]  offset;
    logic [7:0]  target;
    logic [7:0]  rdata;
  } state_s;

  localparam logic [15:0] CONV_LAST = 16'(MEAS_CYCLES - 1);
  localparam logic [7:0]  FRAME_LAST = 8'(MEAS_FRAMES - 1);

  state_s state_q;
  state_s state_d;

  // offset in 30 mV steps from temperature code and four slope selectors
  function automatic logic [7:0] calc_offset(
    input logic [7:0] t,
    input logic [2:0] sa,
    input logic [2:0] sb,
    input logic [2:0] sc,
    input logic [2:0] sd
  );
    logic signed [19:0] t16;
    logic signed [19:0] fa;
    logic signed [19:0] fb;
    logic signed [19:0] fc;
    logic signed [19:0] fd;
    logic signed [19:0] mv16;
    logic signed [19:0] steps;
    t16 = $signed({12'h000, t}) * T16_GAIN - T16_BASE;
    fa = 20'(slope_mv(sa));
    fb = 20'(slope_mv(sb));
    fc = 20'(slope_mv(sc));
    fd = 20'(slope_mv(sd));
    if (t <= EDGE_M40)
      mv16 = SPAN16 * fa + SPAN16 * fb;
    else if (t <= EDGE_M10)
      mv16 = (T16_M10 - t16) * fa + SPAN16 * fb;
    else if (t <= EDGE_P20)
      mv16 = (T16_P20 - t16) * fb;
    else if (t <= EDGE_P50)
      mv16 = (t16 - T16_P20) * fc;
    else if (t < EDGE_P80)
      mv16 = (t16 - T16_P50) * fd + SPAN16 * fc;
    else
      mv16 = SPAN16 * fd + SPAN16 * fc;
    // truncation toward zero keeps the 20 degC point exactly at zero
    steps = mv16 / STEP16;
    calc_offset = steps[7:0];
  endfunction

  always_comb
  begin
    logic signed [9:0] sum;
    logic        conv_done;
    logic [7:0]  sample;
    logic [8:0]  gap;
    sum = 10'sd0;
    conv_done = 1'b0;
    sample = 8'h00;
    gap = 9'h000;
    state_d = state_q;
    state_d.fresh = 1'b0;

    if (reg_write)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          state_d.measure_enable = reg_wdata[CTRL_MEAS_BIT];
          state_d.comp_enable    = reg_wdata[CTRL_COMP_BIT];
          state_d.pump_enable    = reg_wdata[CTRL_PUMP_BIT];
          state_d.pump_mult      = reg_wdata[CTRL_MULT_BIT];
          state_d.filter_enable  = reg_wdata[CTRL_FILT_BIT];
          state_d.ext_supply     = reg_wdata[CTRL_EXT_BIT];
        end
        REG_VPROG:
          state_d.vprog = reg_wdata;
        REG_SLOPE_AB:
        begin
          state_d.sel_a = reg_wdata[SLOPE_LO_POS +: 3];
          state_d.sel_b = reg_wdata[SLOPE_HI_POS +: 3];
        end
        REG_SLOPE_CD:
        begin
          state_d.sel_c = reg_wdata[SLOPE_LO_POS +: 3];
          state_d.sel_d = reg_wdata[SLOPE_HI_POS +: 3];
        end
        default:
          state_d.vprog = state_q.vprog;
      endcase
    end

    // periodic measurement, interval counted in frames
    case (state_q.meas)
      MEAS_IDLE:
      begin
        state_d.conv_cnt = 16'h0000;
        if (!state_q.measure_enable)
          state_d.frame_cnt = 8'h00;
        else if (frame_tick)
        begin
          if (state_q.frame_cnt == FRAME_LAST)
          begin
            state_d.frame_cnt = 8'h00;
            state_d.meas = MEAS_CONVERT;
          end
          else
            state_d.frame_cnt = state_q.frame_cnt + 8'h01;
        end
      end
      MEAS_CONVERT:
      begin
        // dropping the enable abandons the running conversion
        if (!state_q.measure_enable)
          state_d.meas = MEAS_IDLE;
        else if (state_q.conv_cnt == CONV_LAST)
        begin
          state_d.meas = MEAS_IDLE;
          conv_done = 1'b1;
        end
        else
          state_d.conv_cnt = state_q.conv_cnt + 16'h0001;
      end
      default:
        state_d.meas = MEAS_IDLE;
    endcase

    if (conv_done)
    begin
      sample = sensor_code;
      state_d.raw = sample;
      state_d.fresh = 1'b1;
      if (!state_q.filter_enable)
      begin
        state_d.temp = sample;
        state_d.trend = 2'b00;
      end
      else
      begin
        // step one LSB toward the sample, only on a jump of two or more
        // or on two same-sign differences in a row: slow but jitter-free
        gap = {1'b0, sample} - {1'b0, state_q.temp};
        if (sample > state_q.temp)
        begin
          if (gap > 9'h001 || state_q.trend == 2'b01)
          begin
            state_d.temp = state_q.temp + 8'h01;
            state_d.trend = 2'b00;
          end
          else
            state_d.trend = 2'b01;
        end
        else if (sample < state_q.temp)
        begin
          if (gap < 9'h1FF || state_q.trend == 2'b10)
          begin
            state_d.temp = state_q.temp - 8'h01;
            state_d.trend = 2'b00;
          end
          else
            state_d.trend = 2'b10;
        end
        else
          state_d.trend = 2'b00;
      end
    end

    // offset follows the current temperature value
    if (state_q.comp_enable && !state_q.ext_supply)
      state_d.offset = calc_offset(state_q.temp, state_q.sel_a,
                                   state_q.sel_b, state_q.sel_c,
                                   state_q.sel_d);
    else
      state_d.offset = 8'h00;

    sum = $signed({2'b00, state_q.vprog})
        + $signed({{2{state_q.offset[7]}}, state_q.offset});
    if (sum < 10'sd0)
      state_d.target = 8'h00;
    else if (sum > $signed({2'b00, LCD_DRIVE_VOLTAGE_MAX_CODE}))
      state_d.target = LCD_DRIVE_VOLTAGE_MAX_CODE;
    else
      state_d.target = sum[7:0];

    state_d.rdata = 8'h00;
    if (reg_read)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          state_d.rdata[CTRL_MEAS_BIT] = state_q.measure_enable;
          state_d.rdata[CTRL_COMP_BIT] = state_q.comp_enable;
          state_d.rdata[CTRL_PUMP_BIT] = state_q.pump_enable;
          state_d.rdata[CTRL_MULT_BIT] = state_q.pump_mult;
          state_d.rdata[CTRL_FILT_BIT] = state_q.filter_enable;
          state_d.rdata[CTRL_EXT_BIT]  = state_q.ext_supply;
        end
        REG_VPROG:
          state_d.rdata = state_q.vprog;
        REG_SLOPE_AB:
        begin
          state_d.rdata[SLOPE_LO_POS +: 3] = state_q.sel_a;
          state_d.rdata[SLOPE_HI_POS +: 3] = state_q.sel_b;
        end
        REG_SLOPE_CD:
        begin
          state_d.rdata[SLOPE_LO_POS +: 3] = state_q.sel_c;
          state_d.rdata[SLOPE_HI_POS +: 3] = state_q.sel_d;
        end
        REG_TEMP:
          state_d.rdata = state_q.temp;
        REG_OFFSET:
          state_d.rdata = state_q.offset;
        REG_TARGET:
          state_d.rdata = state_q.target;
        REG_STATUS:
        begin
          state_d.rdata[STAT_CONV_BIT] = (state_q.meas == MEAS_CONVERT);
          state_d.rdata[STAT_PUMP_BIT] = state_q.pump_enable;
          state_d.rdata[STAT_DIFF_BIT] = (state_q.raw != state_q.temp);
        end
        default:
          state_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= '0;
      state_q.measure_enable <= CTRL_RESET[CTRL_MEAS_BIT];
      state_q.comp_enable    <= CTRL_RESET[CTRL_COMP_BIT];
      state_q.pump_enable    <= CTRL_RESET[CTRL_PUMP_BIT];
      state_q.pump_mult      <= CTRL_RESET[CTRL_MULT_BIT];
      state_q.filter_enable  <= CTRL_RESET[CTRL_FILT_BIT];
      state_q.ext_supply     <= CTRL_RESET[CTRL_EXT_BIT];
      state_q.vprog <= VPROG_RESET;
      state_q.sel_a <= SLOPE_RESET;
      state_q.sel_b <= SLOPE_RESET;
      state_q.sel_c <= SLOPE_RESET;
      state_q.sel_d <= SLOPE_RESET;
      state_q.meas  <= MEAS_IDLE;
      state_q.raw   <= TEMP_RESET;
      state_q.temp  <= TEMP_RESET;
      state_q.target <= VPROG_RESET;
    end
    else
      state_q <= state_d;
  end

  assign reg_rdata          = state_q.rdata;
  assign sensor_active      = (state_q.meas == MEAS_CONVERT);
  assign temp_update        = state_q.fresh;
  // the pump is not gated by the external-supply bit: host's duty
  assign pump_on            = state_q.pump_enable;
  assign pump_triple        = state_q.pump_mult;
  assign drive_target_code  = state_q.target;
  // an external supply ignores the programmed code entirely
  assign drive_target_valid = state_q.pump_enable && !state_q.ext_supply;

  sequence s_conv_start;
    $rose(sensor_active) && state_q.measure_enable;
  endsequence

  // a host that drops the enable may cut the conversion short
  sequence s_conv_hold;
    (sensor_active || !state_q.measure_enable)[*4];
  endsequence

  a_conv_runs: assert property (
    @(posedge clock) disable iff (reset)
    s_conv_start ##1 state_q.measure_enable[*3] |-> s_conv_hold)
    else $error("conversion ended too early");

  a_conv_stop: assert property (
    @(posedge clock) disable iff (reset)
    !state_q.measure_enable && sensor_active |=> !sensor_active)
    else $error("conversion kept running while disabled");

  a_target_limit: assert property (
    @(posedge clock) disable iff (reset)
    drive_target_code <= LCD_DRIVE_VOLTAGE_MAX_CODE)
    else $error("drive target above 9 V");

  a_ext_no_drive: assert property (
    @(posedge clock) disable iff (reset)
    state_q.ext_supply |-> !drive_target_valid ##1 state_q.offset == 8'h00)
    else $error("external supply still compensated");

  a_pump_follow: assert property (
    @(posedge clock) disable iff (reset)
    reg_write && reg_addr == REG_CTRL
      |=> pump_on == $past(reg_wdata[CTRL_PUMP_BIT]))
    else $error("pump does not follow its enable");

  a_mult_follow: assert property (
    @(posedge clock) disable iff (reset)
    reg_write && reg_addr == REG_CTRL
      |=> pump_triple == $past(reg_wdata[CTRL_MULT_BIT]))
    else $error("multiplier does not follow its bit");

  a_raw_bypass: assert property (
    @(posedge clock) disable iff (reset)
    temp_update && !$past(state_q.filter_enable)
      |-> state_q.temp == state_q.raw)
    else $error("unfiltered temperature not used");

  a_filter_step: assert property (
    @(posedge clock) disable iff (reset)
    temp_update && $past(state_q.filter_enable)
      |-> (state_q.temp - $past(state_q.temp) <= 8'h01)
       || ($past(state_q.temp) - state_q.temp <= 8'h01))
    else $error("filter moved more than one step");

  a_comp_off: assert property (
    @(posedge clock) disable iff (reset)
    (!state_q.comp_enable)[*2] |-> state_q.offset == 8'h00)
    else $error("offset present with compensation off");

  a_zero_at_20: assert property (
    @(posedge clock) disable iff (reset)
    (state_q.temp == TEMP_RESET)[*2] |-> state_q.offset == 8'h00)
    else $error("offset not zero at 20 degC");

  a_no_wrap: assert property (
    @(posedge clock) disable iff (reset)
    state_q.offset[7] && state_q.vprog < (8'h00 - state_q.offset)
      |=> drive_target_code == 8'h00)
    else $error("underflow wrapped");

endmodule
`default_nettype wire

//--- tb/sensor_model.sv
`timescale 1ns/1ns
`default_nettype none
module sensor_model
#(
  parameter int TICK_GAP = 2
)
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       sensor_active,
  input  wire logic [7:0] temp_value,
  output logic            frame_tick,
  output logic      [7:0] sensor_code
);
  logic [7:0] gap_q;
  logic [7:0] idle_q;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      gap_q <= 8'h00;
      idle_q <= 8'h00;
    end
    else
    begin
      gap_q <= (gap_q == 8'(TICK_GAP - 1)) ? 8'h00 : gap_q + 8'h01;
      idle_q <= idle_q + 8'h5B;
    end
  end

  // short frames keep the 200-frame measurement interval cheap
  assign frame_tick = (gap_q == 8'h00) && !reset;
  // result is only defined during a conversion; a moving pattern elsewhere
  // exposes a design that samples at the wrong moment
  assign sensor_code = sensor_active ? temp_value : idle_q;
endmodule
`default_nettype wire

//--- tb/lcd_voltage_temp_compensation_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_voltage_temp_compensation_tb_top;
  import lcd_comp_pkg::*;
  localparam int MEAS_N = 20;
  logic       clock, reset, reg_write, reg_read, frame_tick;
  logic       rd_q = 1'b0;
  logic       sensor_active, temp_update, pump_on, pump_triple;
  logic       drive_target_valid;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sensor_code, drive_target_code;
  logic [7:0] temp_value;
  logic [7:0] exp_q[$];
  int         err_count, tests_run, cycles, seed;
  int         act_n, tick_n;
  int         sf[8] = '{0, -4, -8, -16, -40, 4, 8, 16};
  logic [7:0] codes[8] = '{8'h00, 8'h10, 8'h2A, 8'h40,
                           8'h55, 8'h70, 8'h90, 8'hFF};

  lcd_voltage_comp #(.MEAS_CYCLES(MEAS_N)) lcd_voltage_comp_i (
    .clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .frame_tick(frame_tick),
    .sensor_code(sensor_code), .sensor_active(sensor_active),
    .temp_update(temp_update), .pump_on(pump_on),
    .pump_triple(pump_triple), .drive_target_code(drive_target_code),
    .drive_target_valid(drive_target_valid));

  sensor_model #(.TICK_GAP(2)) sensor_model_i (
    .clock(clock), .reset(reset), .sensor_active(sensor_active),
    .temp_value(temp_value), .frame_tick(frame_tick),
    .sensor_code(sensor_code));

  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // strobes stay up until the next call so none is assigned twice per step
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [7:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic wait_temp;
    int n;
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (temp_update !== 1'b1 && n < 2000);
    if (n >= 2000)
      check(8'hEE, 8'h00);
    repeat (3) @(posedge clock);
  endtask

  function automatic int exp_off(input int code, input int a, input int b,
                                 input int c, input int d);
    int t;
    int m;
    t = code * 15 - 640;
    if (t <= -640)
      m = 480 * (a + b);
    else if (t <= -160)
      m = (-160 - t) * a + 480 * b;
    else if (t <= 320)
      m = (320 - t) * b;
    else if (t <= 800)
      m = (t - 320) * c;
    else if (t < 1280)
      m = (t - 800) * d + 480 * c;
    else
      m = 480 * (c + d);
    return m / 480;
  endfunction

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // read data is looked at only in the cycle after the strobe
  always @(negedge clock)
  begin
    if (rd_q && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());
    rd_q = reg_read;
  end

  // conversion length and frames between conversions, seen at the pins
  always @(negedge clock)
  begin
    if (sensor_active)
    begin
      if (act_n == 0)
        check(8'(tick_n), 8'(MEAS_FRAMES));
      act_n++;
      tick_n = 0;
    end
    else
    begin
      if (act_n != 0)
        check(8'(act_n), 8'(MEAS_N));
      act_n = 0;
      if (frame_tick)
        tick_n++;
    end
  end

  initial
  begin
    logic [2:0] sa, sb, sc, sd;
    logic [7:0] vp, tgt;
    int         off, sum;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    temp_value = 8'h40;
    seed = 66;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(REG_CTRL, 8'h03);
    rd(REG_TEMP, 8'h40);
    rd(REG_OFFSET, 8'h00);
    rd(REG_VPROG, 8'h00);
    rd(4'h8, 8'h00);
    check({7'h00, pump_on}, 8'h00);
    wr(REG_CTRL, 8'h07);
    wr(REG_CTRL, 8'h0F);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    @(posedge clock);
    check({6'h00, pump_on, pump_triple}, 8'h03);
    check({7'h00, drive_target_valid}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      sa = 3'(i);
      sb = 3'(i + 1);
      sc = 3'(i + 2);
      sd = 3'(i + 3);
      vp = 8'($random(seed));
      if (i == 6)
        vp = 8'hFF;
      if (i == 7)
        vp = 8'h00;
      wr(REG_SLOPE_AB, {1'b0, sb, 1'b0, sa});
      wr(REG_SLOPE_CD, {1'b0, sd, 1'b0, sc});
      wr(REG_VPROG, vp);
      temp_value <= codes[i];
      wait_temp();
      off = exp_off(codes[i], sf[sa], sf[sb], sf[sc], sf[sd]);
      sum = int'(vp) + off;
      tgt = (sum < 0) ? 8'h00 : (sum > 200) ? 8'd200 : 8'(sum);
      rd(REG_TEMP, codes[i]);
      rd(REG_OFFSET, 8'(off));
      rd(REG_TARGET, tgt);
      rd(REG_VPROG, vp);
      check(drive_target_code, tgt);
    end
    wr(REG_CTRL, 8'h1F);
    temp_value <= 8'hF0;
    wait_temp();
    rd(REG_TEMP, 8'hFE);
    rd(REG_STATUS, 8'h06);
    wr(REG_CTRL, 8'h0D);
    wr(REG_VPROG, 8'h64);
    wait_temp();
    rd(REG_OFFSET, 8'h00);
    rd(REG_TARGET, 8'h64);
    // external supply: pump kept off by the host
    wr(REG_CTRL, 8'h23);
    wait_temp();
    rd(REG_OFFSET, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    check({6'h00, pump_on, drive_target_valid}, 8'h00);
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule
`default_nettype wire
